//--- sfc_defines.svh
// Constants for the system clock frequency check
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// Source select codes
`define SFC_SRC_LOCO       2'h0
`define SFC_SRC_SUBXTAL    2'h1
`define SFC_SRC_EXTTIMER   2'h2
`define SFC_SRC_PIN        2'h3

// Status codes
`define SFC_ST_PASS        2'h0
`define SFC_ST_WINDOW      2'h1
`define SFC_ST_NOREF       2'h2

// Counter mode loop cost in system clocks per increment
`define SFC_LOOP_CYCLES    4'h9

// Timeout without a reference edge, in system clocks
// Must exceed the longest half period of the slowest reference in use
`define SFC_TIMEOUT_CYCLES 20'h04e20

// Widths
`define SFC_CNT_W          16
`define SFC_TMO_W          20

`endif

//--- sfc_pkg.sv
// Types for the system clock frequency check
package sfc_pkg;
	typedef enum logic {
		SFC_MODE_CAPTURE,
		SFC_MODE_COUNTER
	} sfc_mode_t;

	typedef enum logic [2:0] {
		SFC_IDLE,
		SFC_SYNC,
		SFC_ARM,
		SFC_MEASURE,
		SFC_EVAL
	} sfc_state_t;
endpackage : sfc_pkg

//--- sfc_edge_sync.sv
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/10ps
`include "sfc_defines.svh"

module sfc_edge_sync (
	input  wire logic i_clk_sys,
	input  wire logic i_resetn,
	input  wire logic i_async,
	output logic      o_rise,
	output logic      o_fall
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign o_rise = sync_q & ~prev_q;
	assign o_fall = ~sync_q & prev_q;
endmodule : sfc_edge_sync

//--- sfc_clock_check.sv
// System clock frequency check against a slow reference clock
//
// Contract
// - Status is 0 pass, 1 out of window, 2 no reference clock.
// - Capture and counter methods report the same status encoding.
// - Capture reference selects low-speed oscillator, sub crystal or timer input.
// - Capture mode discards the first edge and measures to the next.
// - Capture value is system clocks in one full reference period.
// - After second capture compare count with upper and lower limits.
// - Limits are user-set; counter mode reads a reference input pin.
// - Counter mode first waits for a falling edge on the pin.
// - Then waits for a rising edge and starts counting from zero.
// - Counter runs until next falling edge, the high phase.
// - At interval end compare count with limits, report violation.
// - One counter increment costs nine system clocks.
// - Counter window is half a reference period.
`timescale 1ns/10ps
`include "sfc_defines.svh"

module sfc_clock_check (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_resetn,
	input  wire logic                      i_start,
	input  wire logic                      i_mode_counter,
	input  wire logic [1:0]                i_capture_source_select,
	input  wire logic                      i_low_speed_osc_clock,
	input  wire logic                      i_sub_clock_crystal,
	input  wire logic                      i_external_timer_input,
	input  wire logic                      i_reference_input_pin,
	input  wire logic [`SFC_CNT_W-1:0]     i_counter_upper_limit,
	input  wire logic [`SFC_CNT_W-1:0]     i_counter_lower_limit,
	output logic                           o_busy,
	output logic                           o_done,
	output logic [1:0]                     o_status,
	output logic [`SFC_CNT_W-1:0]          o_measured
);
	sfc_pkg::sfc_state_t        state_q;
	sfc_pkg::sfc_mode_t         mode_q;
	logic [`SFC_CNT_W-1:0]      count_q;
	logic [3:0]                 loop_q;
	logic [`SFC_TMO_W-1:0]      tmo_q;
	logic                       ref_sel;
	logic                       ref_rise;
	logic                       ref_fall;
	logic                       sync_ev;
	logic                       arm_ev;
	logic                       end_ev;
	logic                       edge_seen;
	logic                       timeout;

	function automatic logic [1:0] judge(input logic [`SFC_CNT_W-1:0] v,
		input logic [`SFC_CNT_W-1:0] hi, input logic [`SFC_CNT_W-1:0] lo);
		judge = (v > hi || v < lo) ? `SFC_ST_WINDOW : `SFC_ST_PASS;
	endfunction : judge

	////////////////////////////////////////////////////////////////////////
	// Reference selection
	// source select; counter pin
	always_comb begin
		if (i_mode_counter) begin
			ref_sel = i_reference_input_pin;
		end else begin
			unique case (i_capture_source_select)
				`SFC_SRC_LOCO:     ref_sel = i_low_speed_osc_clock;
				`SFC_SRC_SUBXTAL:  ref_sel = i_sub_clock_crystal;
				default:           ref_sel = i_external_timer_input;
			endcase
		end
	end

	// Switching source mid-run may give a spurious edge; caller holds it
	sfc_edge_sync u_sync (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_async   (ref_sel),
		.o_rise    (ref_rise),
		.o_fall    (ref_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// Edge roles per mode
	// capture uses rising edges; counter edges
	always_comb begin
		if (mode_q == sfc_pkg::SFC_MODE_COUNTER) begin
			sync_ev = ref_fall;
			arm_ev  = ref_rise;
			end_ev  = ref_fall;
		end else begin
			sync_ev = ref_rise;
			arm_ev  = 1'b0;
			end_ev  = ref_rise;
		end
	end

	assign edge_seen = ref_rise | ref_fall;
	assign timeout   = (tmo_q == `SFC_TIMEOUT_CYCLES - 20'h1);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			state_q <= sfc_pkg::SFC_IDLE;
			mode_q  <= sfc_pkg::SFC_MODE_CAPTURE;
		end else begin
			unique case (state_q)
				sfc_pkg::SFC_IDLE: begin
					if (i_start) begin
						state_q <= sfc_pkg::SFC_SYNC;
						mode_q  <= i_mode_counter ? sfc_pkg::SFC_MODE_COUNTER
						                          : sfc_pkg::SFC_MODE_CAPTURE;
					end
				end
				// discard first capture; wait for fall
				sfc_pkg::SFC_SYNC: begin
					if (timeout) begin
						state_q <= sfc_pkg::SFC_EVAL;
					end else if (sync_ev) begin
						state_q <= (mode_q == sfc_pkg::SFC_MODE_COUNTER)
						           ? sfc_pkg::SFC_ARM : sfc_pkg::SFC_MEASURE;
					end
				end
				sfc_pkg::SFC_ARM: begin
					if (timeout) begin
						state_q <= sfc_pkg::SFC_EVAL;
					end else if (arm_ev) begin
						state_q <= sfc_pkg::SFC_MEASURE;
					end
				end
				sfc_pkg::SFC_MEASURE: begin
					if (timeout || end_ev) begin
						state_q <= sfc_pkg::SFC_EVAL;
					end
				end
				sfc_pkg::SFC_EVAL: begin
					state_q <= sfc_pkg::SFC_IDLE;
				end
				// Unused codes fall back to idle
				default: begin
					state_q <= sfc_pkg::SFC_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timeout counter, restarted by every reference edge
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			tmo_q <= '0;
		end else if (state_q == sfc_pkg::SFC_IDLE || state_q == sfc_pkg::SFC_EVAL
		             || edge_seen) begin
			tmo_q <= '0;
		end else begin
			tmo_q <= tmo_q + `SFC_TMO_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Measurement counter
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			count_q <= '0;
			loop_q  <= '0;
		end else if (state_q != sfc_pkg::SFC_MEASURE) begin
			// capture count and counter loop start from one; the arming clock is already counted
			if (state_q == sfc_pkg::SFC_SYNC && sync_ev
			    && mode_q == sfc_pkg::SFC_MODE_CAPTURE) begin
				count_q <= `SFC_CNT_W'(1);
			end else begin
				count_q <= '0;
			end
			if (state_q == sfc_pkg::SFC_ARM && arm_ev) begin
				loop_q <= 4'h1;
			end else begin
				loop_q <= '0;
			end
		end else if (mode_q == sfc_pkg::SFC_MODE_CAPTURE) begin
			// one count per system clock, saturating
			if (!end_ev && count_q != '1) begin
				count_q <= count_q + `SFC_CNT_W'(1);
			end
		end else if (!end_ev) begin
			if (loop_q == `SFC_LOOP_CYCLES - 4'h1) begin
				loop_q <= '0;
				if (count_q != '1) begin
					count_q <= count_q + `SFC_CNT_W'(1);
				end
			end else begin
				loop_q <= loop_q + 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Result
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_status   <= `SFC_ST_PASS;
			o_measured <= '0;
			o_done     <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (state_q == sfc_pkg::SFC_MEASURE && end_ev && !timeout) begin
				o_status   <= judge(count_q, i_counter_upper_limit, i_counter_lower_limit);
				o_measured <= count_q;
				o_done     <= 1'b1;
			end else if (state_q != sfc_pkg::SFC_IDLE && state_q != sfc_pkg::SFC_EVAL
			             && timeout) begin
				o_status   <= `SFC_ST_NOREF;
				o_measured <= count_q;
				o_done     <= 1'b1;
			end
		end
	end

	assign o_busy = (state_q != sfc_pkg::SFC_IDLE);
endmodule : sfc_clock_check

//--- sfc_clock_check_assertions.sv
// Port-level assertions for the system clock frequency check
`timescale 1ns/10ps
`include "sfc_defines.svh"
module sfc_clock_check_assertions (
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_resetn,
	input  wire logic                  i_start,
	input  wire logic [`SFC_CNT_W-1:0] i_counter_upper_limit,
	input  wire logic [`SFC_CNT_W-1:0] i_counter_lower_limit,
	input  wire logic                  o_busy,
	input  wire logic                  o_done,
	input  wire logic [1:0]            o_status,
	input  wire logic [`SFC_CNT_W-1:0] o_measured
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);
	a_status_code: assert property (o_done |-> o_status <= `SFC_ST_NOREF)
		else $error("status code out of range");
	a_window_cmp: assert property (o_done && o_status != `SFC_ST_NOREF |->
		(o_status == `SFC_ST_WINDOW) ==
		(o_measured > i_counter_upper_limit || o_measured < i_counter_lower_limit))
		else $error("window verdict disagrees with limits");
	a_done_pulse: assert property (o_done |=> !o_done)
		else $error("done longer than one cycle");
	a_busy_done: assert property (o_done |-> o_busy ##1 !o_busy)
		else $error("busy not ending right after done");
	a_start_take: assert property (!o_busy && i_start |=> o_busy)
		else $error("start not taken while idle");
	a_status_hold: assert property (!o_done |-> $stable(o_status))
		else $error("status moved without done");
	a_meas_hold: assert property (!o_done |-> $stable(o_measured))
		else $error("measured moved without done");
	a_sync_delay: assert property ($rose(o_busy) |-> !o_done [*3])
		else $error("done too soon for the synchroniser");
endmodule : sfc_clock_check_assertions

//--- sfc_ref_model.sv
// Reference clock source model with settable half period
`timescale 1ns/10ps
module sfc_ref_model (
	input  wire logic        i_en,
	input  wire logic [15:0] i_half_ns,
	output logic             o_ref
);
	// free square wave
	// Disabled source stays low, as a stopped oscillator would
	initial begin
		o_ref = 1'b0;
		#3;
		forever begin
			#(i_half_ns);
			o_ref = i_en ? ~o_ref : 1'b0;
		end
	end
endmodule : sfc_ref_model

//--- sfc_clock_check_bench.sv
// Self-checking bench for the system clock frequency check
`timescale 1ns/10ps
`include "sfc_defines.svh"
module sfc_clock_check_bench;
	logic        i_clk_sys, i_resetn, i_start, i_mode_counter, ref_en, wave;
	logic [1:0]  i_capture_source_select, o_status;
	logic [15:0] half_ns, o_measured, up_lim, lo_lim;
	logic        o_busy, o_done;
	int          n_mismatch, tests_run;
	sfc_ref_model REF (.i_en(ref_en), .i_half_ns(half_ns), .o_ref(wave));
	// In capture mode only the selected source carries the wave, so a wrong pick reads as no reference
	sfc_clock_check DUT (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_start(i_start),
		.i_mode_counter(i_mode_counter), .i_capture_source_select(i_capture_source_select),
		.i_low_speed_osc_clock(wave & (i_capture_source_select == 2'h0)),
		.i_sub_clock_crystal(wave & (i_capture_source_select == 2'h1)),
		.i_external_timer_input(wave & i_capture_source_select[1]),
		.i_reference_input_pin(wave & i_mode_counter),
		.i_counter_upper_limit(up_lim), .i_counter_lower_limit(lo_lim),
		.o_busy(o_busy), .o_done(o_done), .o_status(o_status), .o_measured(o_measured));
	task automatic end_of_test;
		$display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test
	task automatic run_check(input logic m, input logic [1:0] s, input logic [15:0] u,
			input logic [15:0] l, input logic [1:0] st, input logic [15:0] em);
		int k;
		i_mode_counter = m;
		i_capture_source_select = s;
		force_lim(u, l);
		i_start = 1'b1;
		@(posedge i_clk_sys);
		#1 i_start = 1'b0;
		k = 0;
		while (o_done !== 1'b1 && k < `SFC_TIMEOUT_CYCLES + 1000) begin
			@(posedge i_clk_sys);
			#1 k++;
		end
		tests_run++;
		if (k >= `SFC_TIMEOUT_CYCLES + 1000) begin
			n_mismatch++;
			$display("[ERR] %0t no done", $time);
			end_of_test();
		end
		if (o_status !== st || (em !== 16'hffff && o_measured !== em)) begin
			n_mismatch++;
			$display("[ERR] %0t status %0d count %0d", $time, o_status, o_measured);
		end
		@(posedge i_clk_sys);
		#1;
	endtask : run_check
	task automatic force_lim(input logic [15:0] u, input logic [15:0] l);
		up_lim = u;
		lo_lim = l;
	endtask : force_lim
	initial begin
		i_clk_sys = 1'b0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		{i_resetn, i_start, i_mode_counter} = 3'h0;
		i_capture_source_select = 2'h0;
		ref_en = 1'b1;
		half_ns = 16'h00c8;
		n_mismatch = 0;
		tests_run = 0;
		repeat (3) @(posedge i_clk_sys);
		#1 i_resetn = 1'b1;
		// Period of 40 clocks gives a capture of 40
		for (int s = 0; s < 4; s++)
			run_check(1'b0, s[1:0], 16'h0028, 16'h0028, 2'h0, 16'h0028);
		run_check(1'b0, 2'h0, 16'h0027, 16'h0000, 2'h1, 16'h0028);
		run_check(1'b0, 2'h1, 16'h0030, 16'h0029, 2'h1, 16'h0028);
		// High phase of 90 clocks is ten loops of nine
		half_ns = 16'h0384;
		run_check(1'b1, 2'h0, 16'h000b, 16'h0009, 2'h0, 16'h000a);
		run_check(1'b1, 2'h0, 16'h0014, 16'h000c, 2'h1, 16'h000a);
		ref_en = 1'b0;
		#2000;
		run_check(1'b0, 2'h0, 16'hffff, 16'h0000, 2'h2, 16'hffff);
		// Reset in the middle of a check clears the result and returns to idle
		i_start = 1'b1;
		@(posedge i_clk_sys);
		#1 i_start = 1'b0;
		i_resetn = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1 i_resetn = 1'b1;
		tests_run++;
		if (o_busy !== 1'b0 || o_done !== 1'b0 || o_status !== 2'h0
		    || o_measured !== 16'h0000) begin
			n_mismatch++;
			$display("[ERR] %0t outputs not cleared by reset", $time);
		end
		end_of_test();
	end
endmodule : sfc_clock_check_bench
bind sfc_clock_check sfc_clock_check_assertions CHK (.i_clk_sys(i_clk_sys),
	.i_resetn(i_resetn), .i_start(i_start), .i_counter_upper_limit(i_counter_upper_limit),
	.i_counter_lower_limit(i_counter_lower_limit), .o_busy(o_busy), .o_done(o_done),
	.o_status(o_status), .o_measured(o_measured));
